// File: src/synth_ctrl_pkg.sv
// Shared constants and carrier types for the reference path and output multiplexer control
package synth_ctrl_pkg;
	localparam int ADDR_BITS = 15;
	localparam int FRAME_BITS = 24;
	localparam int REF_COUNT_BITS = 5;
	localparam logic [14:0] ADDR_LOOP_CONTROL = 15'h001e;
	localparam logic [14:0] ADDR_REF_DIVIDER = 15'h001f;
	localparam logic [14:0] ADDR_MUX_CONTROL = 15'h0020;
	localparam logic [14:0] ADDR_REF_CONFIG = 15'h0022;
	localparam int COUNTER_HOLD_BIT = 0;
	localparam int POWER_DOWN_BIT = 2;
	localparam int MUX_SEL_LSB = 4;
	localparam int MUX_ENABLE_BIT = 3;
	localparam int LEVEL_SELECT_BIT = 2;
	localparam int REF_TYPE_BIT = 6;
	localparam int DOUBLER_BIT = 5;
	localparam int HALF_DIVIDER_BIT = 4;
	localparam logic [7:0] LOOP_CONTROL_MASK = 8'h05;
	localparam logic [7:0] REF_DIVIDER_MASK = 8'h1f;
	localparam logic [7:0] MUX_CONTROL_MASK = 8'hfc;
	localparam logic [7:0] REF_CONFIG_MASK = 8'h70;
	localparam logic [7:0] LOOP_CONTROL_RESET = 8'h00;
	localparam logic [7:0] REF_DIVIDER_RESET = 8'h01;
	localparam logic [7:0] MUX_CONTROL_RESET = 8'h14;
	localparam logic [7:0] REF_CONFIG_RESET = 8'h00;
	localparam logic [3:0] MUX_TRISTATE = 4'h0;
	localparam logic [3:0] MUX_LOCK_DETECT = 4'h1;
	localparam logic [3:0] MUX_CP_UP = 4'h2;
	localparam logic [3:0] MUX_CP_DOWN = 4'h3;
	localparam logic [3:0] MUX_REF_HALF = 4'h4;
	localparam logic [3:0] MUX_FB_HALF = 4'h5;
	localparam logic [3:0] MUX_VCO_TEST = 4'h6;
	localparam logic [3:0] MUX_HIGH = 4'h8;
	localparam logic [3:0] MUX_CAL_R_BAND = 4'h9;
	localparam logic [3:0] MUX_CAL_N_BAND = 4'ha;

	typedef struct packed {
		logic lock_detect;
		logic cp_up;
		logic cp_down;
		logic vco_test;
		logic cal_r_band;
		logic cal_n_band;
	} mux_src_t;

	typedef struct packed {
		logic en;
		logic [14:0] addr;
		logic [7:0] data;
	} reg_write_t;
endpackage : synth_ctrl_pkg

// File: src/serial_port.sv
// Serial programming port: 24-bit frames, read flag, 15-bit address, 8-bit data
`timescale 1ns/1ps
`default_nettype none
module serial_port (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic [7:0] rd_data,
	output synth_ctrl_pkg::reg_write_t wr,
	output logic [14:0] rd_addr,
	output logic sdo,
	output logic sdo_active
);
	typedef enum logic [1:0] {IDLE, ADDRESS, DATA, DONE} port_state_t;
	port_state_t state, next_state;
	logic [4:0] bit_cnt, next_bit_cnt;
	logic [15:0] shift_in, next_shift_in;
	logic is_read, next_is_read;
	logic [7:0] tx_shift, next_tx_shift;
	logic sclk_prev, next_sdo, next_sdo_active;
	synth_ctrl_pkg::reg_write_t next_wr;
	logic [14:0] next_rd_addr;
	logic rise, fall;

	always_comb begin
		rise = sclk & ~sclk_prev;
		fall = ~sclk & sclk_prev;
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_shift_in = shift_in;
		next_is_read = is_read;
		next_tx_shift = tx_shift;
		next_sdo = sdo;
		next_sdo_active = sdo_active;
		next_rd_addr = rd_addr;
		next_wr = wr;
		next_wr.en = 1'b0;
		if (cs_n) begin
			// Deselect aborts any partial frame, so a short frame never writes
			next_state = IDLE;
			next_bit_cnt = 5'h00;
			next_sdo_active = 1'b0;
		end else begin
			case (state)
				IDLE: begin
					next_state = ADDRESS;
					next_bit_cnt = 5'h00;
				end
				ADDRESS: begin
					if (rise) begin
						next_shift_in = {shift_in[14:0], sdi};
						next_bit_cnt = bit_cnt + 5'h01;
						if (bit_cnt == 5'h0f) begin
							next_is_read = shift_in[14];
							next_rd_addr = {shift_in[13:0], sdi};
							next_state = DATA;
							next_bit_cnt = 5'h00;
						end
					end
				end
				DATA: begin
					if (rise) begin
						next_shift_in = {shift_in[14:0], sdi};
						next_bit_cnt = bit_cnt + 5'h01;
						if (bit_cnt == 5'h07) begin
							next_wr.en = ~is_read;
							next_wr.addr = rd_addr;
							next_wr.data = {shift_in[6:0], sdi};
							next_state = DONE;
						end
					end
					if (fall && is_read) begin
						next_sdo_active = 1'b1;
						if (bit_cnt == 5'h00) begin
							next_sdo = rd_data[7];
							next_tx_shift = {rd_data[6:0], 1'b0};
						end else begin
							next_sdo = tx_shift[7];
							next_tx_shift = {tx_shift[6:0], 1'b0};
						end
					end
				end
				DONE: next_state = DONE;
				default: next_state = IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= IDLE;
			bit_cnt <= 5'h00;
			shift_in <= 16'h0000;
			is_read <= 1'b0;
			tx_shift <= 8'h00;
			sclk_prev <= 1'b0;
			sdo <= 1'b0;
			sdo_active <= 1'b0;
			rd_addr <= 15'h0000;
			wr <= '0;
		end else if (ce) begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			shift_in <= next_shift_in;
			is_read <= next_is_read;
			tx_shift <= next_tx_shift;
			sclk_prev <= sclk;
			sdo <= next_sdo;
			sdo_active <= next_sdo_active;
			rd_addr <= next_rd_addr;
			wr <= next_wr;
		end
	end
endmodule : serial_port
`default_nettype wire

// File: src/ref_path_muxout_control.sv
// Loop control, reference divider, output multiplexer and reference path registers
`timescale 1ns/1ps
`default_nettype none
module ref_path_muxout_control (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic CE,
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic SDIO_IN,
	input wire logic REF_IN,
	input wire logic FB_IN,
	input wire synth_ctrl_pkg::mux_src_t MUX_SRC,
	output logic SDIO_OUT,
	output logic SDIO_OE_N,
	output logic MUXOUT_OUT,
	output logic MUXOUT_OE_N,
	output logic PFD_REF,
	output logic PFD_FB,
	output logic LOOP_POWER_DOWN,
	output logic COUNTER_HOLD,
	output logic REF_INPUT_TYPE,
	output logic REF_DOUBLER_ON,
	output logic OUTPUT_LOGIC_LEVEL_3V3
);
	// Pin order: sclk, cs_n, sdio, ref, fb; chip select idles high
	localparam logic [4:0] PIN_RESET = 5'h08;
	logic [4:0] pin_meta, pin_sync;
	logic [7:0] loop_control, ref_divider, mux_control, ref_config;
	logic [7:0] next_loop_control, next_ref_divider, next_mux_control, next_ref_config;
	logic [7:0] rd_data;
	logic [14:0] rd_addr;
	synth_ctrl_pkg::reg_write_t wr;
	logic sdo, sdo_active;
	logic ref_prev, fb_prev, ref_pulse, r_half, fb_half;
	logic next_ref_pulse, next_r_half, next_fb_half;
	logic [4:0] ref_count, next_ref_count;
	logic ref_edge, fb_edge, hold, mux_en, sel_out;
	logic [3:0] mux_sel;
	logic next_muxout, next_muxout_oe_n, next_sdio_oe_n, next_pfd_ref, next_pfd_fb;

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			pin_meta <= PIN_RESET;
			pin_sync <= PIN_RESET;
		end else if (CE) begin
			pin_meta <= {SCLK, CS_N, SDIO_IN, REF_IN, FB_IN};
			pin_sync <= pin_meta;
		end
	end

	serial_port u_port (
		.clk(CLK_SYS),
		.reset(RESET),
		.ce(CE),
		.sclk(pin_sync[4]),
		.cs_n(pin_sync[3]),
		.sdi(pin_sync[2]),
		.rd_data(rd_data),
		.wr(wr),
		.rd_addr(rd_addr),
		.sdo(sdo),
		.sdo_active(sdo_active)
	);

	always_comb begin
		next_loop_control = loop_control;
		next_ref_divider = ref_divider;
		next_mux_control = mux_control;
		next_ref_config = ref_config;
		if (wr.en) begin
			// Masks keep reserved bits at zero whatever the host sends
			case (wr.addr)
				synth_ctrl_pkg::ADDR_LOOP_CONTROL:
					next_loop_control = wr.data & synth_ctrl_pkg::LOOP_CONTROL_MASK;
				synth_ctrl_pkg::ADDR_REF_DIVIDER:
					next_ref_divider = wr.data & synth_ctrl_pkg::REF_DIVIDER_MASK;
				synth_ctrl_pkg::ADDR_MUX_CONTROL:
					next_mux_control = wr.data & synth_ctrl_pkg::MUX_CONTROL_MASK;
				synth_ctrl_pkg::ADDR_REF_CONFIG:
					next_ref_config = wr.data & synth_ctrl_pkg::REF_CONFIG_MASK;
				default: next_loop_control = loop_control;
			endcase
		end
		case (rd_addr)
			synth_ctrl_pkg::ADDR_LOOP_CONTROL: rd_data = loop_control;
			synth_ctrl_pkg::ADDR_REF_DIVIDER: rd_data = ref_divider;
			synth_ctrl_pkg::ADDR_MUX_CONTROL: rd_data = mux_control;
			synth_ctrl_pkg::ADDR_REF_CONFIG: rd_data = ref_config;
			default: rd_data = 8'h00;
		endcase
	end

	always_comb begin
		// Power-down stops the loop counters too; registers are untouched
		hold = loop_control[synth_ctrl_pkg::COUNTER_HOLD_BIT]
			| loop_control[synth_ctrl_pkg::POWER_DOWN_BIT];
		// Doubler counts both reference edges, an edge-rate stand-in for the analog doubler
		ref_edge = ref_config[synth_ctrl_pkg::DOUBLER_BIT] ? (pin_sync[1] ^ ref_prev)
			: (pin_sync[1] & ~ref_prev);
		fb_edge = pin_sync[0] & ~fb_prev;
		next_ref_count = ref_count;
		next_ref_pulse = 1'b0;
		next_r_half = r_half;
		next_fb_half = fb_half;
		if (hold) begin
			next_ref_count = 5'h00;
			next_r_half = 1'b0;
			next_fb_half = 1'b0;
		end else begin
			if (ref_edge) begin
				// Zero minus one wraps to 31, giving a ratio of thirty-two
				if (ref_count == 5'(ref_divider[4:0] - 5'h01)) begin
					next_ref_count = 5'h00;
					next_ref_pulse = 1'b1;
				end else begin
					next_ref_count = ref_count + 5'h01;
				end
			end
			if (ref_pulse) begin
				next_r_half = ~r_half;
			end
			if (fb_edge) begin
				next_fb_half = ~fb_half;
			end
		end
		next_pfd_ref = hold ? 1'b0 : (ref_config[synth_ctrl_pkg::HALF_DIVIDER_BIT]
			? next_r_half : ref_pulse);
		next_pfd_fb = ~hold & fb_edge;
	end

	always_comb begin
		mux_en = mux_control[synth_ctrl_pkg::MUX_ENABLE_BIT];
		mux_sel = mux_control[synth_ctrl_pkg::MUX_SEL_LSB +: 4];
		case (mux_sel)
			synth_ctrl_pkg::MUX_LOCK_DETECT: sel_out = MUX_SRC.lock_detect;
			synth_ctrl_pkg::MUX_CP_UP: sel_out = MUX_SRC.cp_up;
			synth_ctrl_pkg::MUX_CP_DOWN: sel_out = MUX_SRC.cp_down;
			synth_ctrl_pkg::MUX_REF_HALF: sel_out = r_half;
			synth_ctrl_pkg::MUX_FB_HALF: sel_out = fb_half;
			synth_ctrl_pkg::MUX_VCO_TEST: sel_out = MUX_SRC.vco_test;
			synth_ctrl_pkg::MUX_HIGH: sel_out = 1'b1;
			synth_ctrl_pkg::MUX_CAL_R_BAND: sel_out = MUX_SRC.cal_r_band;
			synth_ctrl_pkg::MUX_CAL_N_BAND: sel_out = MUX_SRC.cal_n_band;
			default: sel_out = 1'b0;
		endcase
		if (mux_en) begin
			next_muxout = sel_out;
			next_muxout_oe_n = 1'b0;
		end else begin
			// Pin becomes read data; code zero floats it between reads
			next_muxout = sdo_active & sdo;
			next_muxout_oe_n = ~sdo_active & (mux_sel == synth_ctrl_pkg::MUX_TRISTATE);
		end
		next_sdio_oe_n = ~(sdo_active & mux_en);
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			loop_control <= synth_ctrl_pkg::LOOP_CONTROL_RESET;
			ref_divider <= synth_ctrl_pkg::REF_DIVIDER_RESET;
			mux_control <= synth_ctrl_pkg::MUX_CONTROL_RESET;
			ref_config <= synth_ctrl_pkg::REF_CONFIG_RESET;
			ref_prev <= 1'b0;
			fb_prev <= 1'b0;
			ref_count <= 5'h00;
			ref_pulse <= 1'b0;
			r_half <= 1'b0;
			fb_half <= 1'b0;
			PFD_REF <= 1'b0;
			PFD_FB <= 1'b0;
			MUXOUT_OUT <= 1'b0;
			MUXOUT_OE_N <= 1'b1;
			SDIO_OUT <= 1'b0;
			SDIO_OE_N <= 1'b1;
			LOOP_POWER_DOWN <= 1'b0;
			COUNTER_HOLD <= 1'b0;
			REF_INPUT_TYPE <= 1'b0;
			REF_DOUBLER_ON <= 1'b0;
			OUTPUT_LOGIC_LEVEL_3V3 <= 1'b1;
		end else if (CE) begin
			loop_control <= next_loop_control;
			ref_divider <= next_ref_divider;
			mux_control <= next_mux_control;
			ref_config <= next_ref_config;
			ref_prev <= pin_sync[1];
			fb_prev <= pin_sync[0];
			ref_count <= next_ref_count;
			ref_pulse <= next_ref_pulse;
			r_half <= next_r_half;
			fb_half <= next_fb_half;
			PFD_REF <= next_pfd_ref;
			PFD_FB <= next_pfd_fb;
			MUXOUT_OUT <= next_muxout;
			MUXOUT_OE_N <= next_muxout_oe_n;
			SDIO_OUT <= sdo;
			SDIO_OE_N <= next_sdio_oe_n;
			LOOP_POWER_DOWN <= loop_control[synth_ctrl_pkg::POWER_DOWN_BIT];
			COUNTER_HOLD <= loop_control[synth_ctrl_pkg::COUNTER_HOLD_BIT];
			REF_INPUT_TYPE <= ref_config[synth_ctrl_pkg::REF_TYPE_BIT];
			REF_DOUBLER_ON <= ref_config[synth_ctrl_pkg::DOUBLER_BIT];
			OUTPUT_LOGIC_LEVEL_3V3 <= mux_control[synth_ctrl_pkg::LEVEL_SELECT_BIT];
		end
	end

	chk_hold_silences_pfd: assert property (@(posedge CLK_SYS) disable iff (RESET)
		CE && loop_control[0] |=> !PFD_REF && !PFD_FB && ref_count == 5'h00)
		else $error("Detector edges seen while counters held");
	chk_power_down_out: assert property (@(posedge CLK_SYS) disable iff (RESET)
		CE && loop_control[2] |=> LOOP_POWER_DOWN && !PFD_REF && !PFD_FB)
		else $error("Power-down did not stop the loop");
	chk_zero_ratio_32: assert property (@(posedge CLK_SYS) disable iff (RESET)
		CE && !hold && ref_edge && ref_divider[4:0] == 5'h00 && ref_count == 5'h1f
		|=> ref_pulse && ref_count == 5'h00)
		else $error("Zero reference count did not divide by 32");
	chk_ratio_count: assert property (@(posedge CLK_SYS) disable iff (RESET)
		CE && !hold && ref_edge && ref_divider[4:0] == 5'h03 && ref_count == 5'h01
		|=> !ref_pulse && ref_count == 5'h02)
		else $error("Reference counter ended early");
	chk_mux_high_code: assert property (@(posedge CLK_SYS) disable iff (RESET)
		CE && mux_control[3] && mux_control[7:4] == 4'h8 |=> MUXOUT_OUT && !MUXOUT_OE_N)
		else $error("Constant-high select not driven");
	chk_tristate_idle: assert property (@(posedge CLK_SYS) disable iff (RESET)
		CE && !mux_control[3] && mux_control[7:4] == 4'h0 && !sdo_active |=> MUXOUT_OE_N)
		else $error("Mux pin not released");
	chk_muxout_read: assert property (@(posedge CLK_SYS) disable iff (RESET)
		CE && !mux_control[3] && sdo_active |=> !MUXOUT_OE_N && MUXOUT_OUT == $past(sdo))
		else $error("Read data missing on mux pin");
	chk_half_stage: assert property (@(posedge CLK_SYS) disable iff (RESET)
		CE && !hold && ref_config[4] && ref_pulse |=> PFD_REF == r_half && r_half != $past(r_half))
		else $error("Divide-by-two stage did not toggle");
	chk_reserved_zero: assert property (@(posedge CLK_SYS) disable iff (RESET)
		ref_divider[7:5] == 3'h0 && mux_control[1:0] == 2'h0 && ref_config[7] == 1'b0
		&& ref_config[3:0] == 4'h0 && loop_control[1] == 1'b0)
		else $error("Reserved bit set");
	chk_reset_values: assert property (@(posedge CLK_SYS)
		$past(RESET) |-> ref_divider == 8'h01 && mux_control == 8'h14 && ref_config == 8'h00)
		else $error("Wrong value after reset");
endmodule : ref_path_muxout_control
`default_nettype wire

// File: verif/serial_host.sv
// Host model that drives the serial programming port frame by frame
`timescale 1ns/1ps
`default_nettype none
module serial_host (
	input wire logic clk,
	input wire logic miso,
	output logic sclk,
	output logic cs_n,
	output logic sdi,
	output logic sdi_oe
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
		sdi_oe = 1'b0;
	end
	// Six cycles a level: the port needs three, and read data lags a pin fall by about four
	task automatic half_bit();
		repeat (6) @(negedge clk);
	endtask : half_bit
	// Fewer than 24 bits aborts the frame
	task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wd,
		input int nb, output logic [7:0] rdat);
		logic [23:0] w;
		w = {rd, addr, wd};
		rdat = 8'h00;
		cs_n = 1'b0;
		for (int i = 0; i < nb; i++) begin
			sdi_oe = !(rd && i >= 16);
			sdi = w[23 - i];
			half_bit();
			if (rd && i >= 16) rdat = {rdat[6:0], miso};
			sclk = 1'b1;
			half_bit();
			sclk = 1'b0;
		end
		half_bit();
		cs_n = 1'b1;
		sdi_oe = 1'b0;
		half_bit();
	endtask : xfer
endmodule : serial_host
`default_nettype wire

// File: verif/ref_path_muxout_control_tb.sv
// Self-checking bench for the control registers, reference path and mux pin
`timescale 1ns/1ps
`default_nettype none
module ref_path_muxout_control_tb;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic ref_in = 1'b0;
	logic fb_in = 1'b0;
	logic toggle = 1'b0;
	logic use_sdio = 1'b0;
	synth_ctrl_pkg::mux_src_t mux_src = '0;
	logic sclk, cs_n, sdi, sdi_oe, miso, sdio;
	logic sdio_out, sdio_oe_n, mux_out, mux_oe_n, pfd_ref, pfd_fb;
	logic pwr_dn, hold, ref_type, doubler, lvl;
	int seed = 32'h3644;
	int num_errors = 0;
	int n_compared = 0;
	int phase = 0;
	logic [7:0] rd, v;
	logic [9:0] iv, cnt;
	logic [7:0] sh [4];
	logic [14:0] ad [4] = '{synth_ctrl_pkg::ADDR_LOOP_CONTROL, synth_ctrl_pkg::ADDR_REF_DIVIDER,
		synth_ctrl_pkg::ADDR_MUX_CONTROL, synth_ctrl_pkg::ADDR_REF_CONFIG};
	logic [7:0] mk [4] = '{synth_ctrl_pkg::LOOP_CONTROL_MASK, synth_ctrl_pkg::REF_DIVIDER_MASK,
		synth_ctrl_pkg::MUX_CONTROL_MASK, synth_ctrl_pkg::REF_CONFIG_MASK};
	logic [7:0] rs [4] = '{8'h00, 8'h01, 8'h14, 8'h00};
	logic [4:0] rv [7] = '{5'h01, 5'h05, 5'h1f, 5'h00, 5'h03, 5'h02, 5'h00};
	logic [7:0] cf [7] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h20, 8'h10, 8'h30};
	logic [7:0] hb [2] = '{8'h01, 8'h04};
	logic [3:0] codes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb};

	always #25 clk_sys = ~clk_sys;
	// Reference period of 8 cycles keeps it far below the sampling clock
	always @(negedge clk_sys) begin
		phase <= phase + 1;
		ref_in <= phase[2];
		fb_in <= phase[3];
		toggle <= ~toggle;
	end
	// Released lines show a changing pattern so a stale value never passes
	assign sdio = !sdio_oe_n ? sdio_out : (sdi_oe ? sdi : toggle);
	assign miso = use_sdio ? (!sdio_oe_n ? sdio_out : toggle) : (!mux_oe_n ? mux_out : toggle);

	serial_host host (.clk(clk_sys), .miso(miso), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
		.sdi_oe(sdi_oe));
	ref_path_muxout_control dut (.CLK_SYS(clk_sys), .RESET(reset), .CE(1'b1), .SCLK(sclk),
		.CS_N(cs_n), .SDIO_IN(sdio), .REF_IN(ref_in), .FB_IN(fb_in), .MUX_SRC(mux_src),
		.SDIO_OUT(sdio_out), .SDIO_OE_N(sdio_oe_n), .MUXOUT_OUT(mux_out),
		.MUXOUT_OE_N(mux_oe_n), .PFD_REF(pfd_ref), .PFD_FB(pfd_fb), .LOOP_POWER_DOWN(pwr_dn),
		.COUNTER_HOLD(hold), .REF_INPUT_TYPE(ref_type), .REF_DOUBLER_ON(doubler),
		.OUTPUT_LOGIC_LEVEL_3V3(lvl));

	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic done(input string n);
		$display("test %s finished", n);
	endtask : done

	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		host.xfer(1'b0, a, d, 24, rd);
	endtask : wr

	task automatic rdchk(input string what, input logic [14:0] a, input logic [7:0] exp);
		host.xfer(1'b1, a, 8'h00, 24, rd);
		check(what, 10'(rd), 10'(exp));
	endtask : rdchk

	// Cycles between two rises of the chosen output: 0 detector reference, 1 mux pin,
	// 2 detector feedback; a missing rise ends the run
	task automatic interval(input int sel, output logic [9:0] n);
		logic p;
		logic s;
		int c;
		int k;
		p = 1'b1;
		s = 1'b0;
		c = -1;
		n = 10'h3ff;
		for (k = 0; k < 1500; k++) begin
			@(negedge clk_sys);
			s = (sel == 0) ? pfd_ref : ((sel == 1) ? mux_out : pfd_fb);
			if (c >= 0) c++;
			if (s === 1'b1 && p === 1'b0) begin
				if (c > 0) break;
				c = 0;
			end
			p = s;
		end
		n = 10'(c);
		if (k == 1500) begin
			num_errors++;
			complete_run();
		end
	endtask : interval

	function automatic logic [9:0] exp_iv(input logic [4:0] r, input logic [7:0] c);
		int n;
		n = (r == 5'h00) ? 32 : int'(r);
		n = n * (c[5] ? 4 : 8) * (c[4] ? 2 : 1);
		return 10'(n);
	endfunction : exp_iv

	function automatic logic exp_mux(input logic [3:0] code, input synth_ctrl_pkg::mux_src_t s);
		case (code)
			synth_ctrl_pkg::MUX_LOCK_DETECT: return s.lock_detect;
			synth_ctrl_pkg::MUX_CP_UP: return s.cp_up;
			synth_ctrl_pkg::MUX_CP_DOWN: return s.cp_down;
			synth_ctrl_pkg::MUX_VCO_TEST: return s.vco_test;
			synth_ctrl_pkg::MUX_HIGH: return 1'b1;
			synth_ctrl_pkg::MUX_CAL_R_BAND: return s.cal_r_band;
			synth_ctrl_pkg::MUX_CAL_N_BAND: return s.cal_n_band;
			default: return 1'b0;
		endcase
	endfunction : exp_mux

	initial begin
		repeat (8) @(negedge clk_sys);
		reset = 1'b0;
		for (int i = 0; i < 4; i++) begin
			sh[i] = rs[i];
			rdchk("reset value", ad[i], rs[i]);
		end
		check("side reset", 10'({pwr_dn, hold, ref_type, doubler, lvl}), 10'h01);
		check("mux pin idle", 10'({mux_oe_n, mux_out}), 10'h0);
		done("reset");
		for (int i = 0; i < 8; i++) begin
			int j;
			j = i % 4;
			v = 8'($random(seed));
			if (j == 2) v[3] = 1'b0;
			wr(ad[j], v);
			sh[j] = v & mk[j];
			rdchk("readback", ad[j], sh[j]);
			check("side outputs", 10'({pwr_dn, hold, ref_type, doubler, lvl}),
				10'({sh[0][2], sh[0][0], sh[3][6], sh[3][5], sh[2][2]}));
		end
		wr(15'h0021, 8'hff);
		rdchk("unmapped", 15'h0021, 8'h00);
		host.xfer(1'b0, ad[1], ~sh[1], 20, rd);
		rdchk("aborted frame", ad[1], sh[1]);
		done("registers");
		wr(ad[0], 8'h00);
		for (int i = 0; i < 7; i++) begin
			wr(ad[1], {3'b000, rv[i]});
			wr(ad[3], cf[i]);
			interval(0, iv);
			interval(0, iv);
			check("reference period", iv, exp_iv(rv[i], cf[i]));
		end
		done("reference path");
		foreach (hb[i]) begin
			wr(ad[0], hb[i]);
			cnt = '0;
			repeat (300) begin
				@(negedge clk_sys);
				cnt = cnt + 10'(pfd_ref | pfd_fb);
			end
			check("detector edges held", cnt, 10'h0);
		end
		rdchk("kept in power-down", ad[3], 8'h30);
		wr(ad[0], 8'h00);
		wr(15'h0010, 8'h00);
		interval(0, iv);
		interval(0, iv);
		check("running again", iv, exp_iv(5'h00, 8'h30));
		// Feedback pin period is 16 cycles, one detector pulse per rising edge
		interval(2, iv);
		interval(2, iv);
		check("feedback running", iv, 10'h010);
		done("hold");
		// Halved divider outputs: reference halves run at twice the divided period
		wr(ad[2], 8'h48);
		interval(1, iv);
		interval(1, iv);
		check("mux reference half", iv, exp_iv(5'h00, 8'h30));
		wr(ad[2], 8'h58);
		interval(1, iv);
		interval(1, iv);
		check("mux feedback half", iv, 10'h020);
		foreach (codes[i]) begin
			wr(ad[2], {codes[i], 4'h8});
			repeat (3) begin
				mux_src = 6'($random(seed));
				repeat (4) @(negedge clk_sys);
				check("mux pin", 10'({mux_oe_n, mux_out}),
					10'({1'b0, exp_mux(codes[i], mux_src)}));
			end
		end
		check("level low", 10'(lvl), 10'h0);
		use_sdio = 1'b1;
		rdchk("three-wire read", ad[2], 8'hb8);
		wr(ad[2], 8'h00);
		use_sdio = 1'b0;
		check("tristate", 10'(mux_oe_n), 10'h1);
		rdchk("four-wire read", ad[2], 8'h00);
		done("mux pin");
		complete_run();
	end
endmodule : ref_path_muxout_control_tb
`default_nettype wire
